//--- hw/mcd_regs.svh
// Purpose: register offsets, field positions, reset values and codes
// Assumes: byte addresses on an APB bus with 32-bit data
// Notes: definitions only
`ifndef MCD_REGS_SVH
`define MCD_REGS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MCD_OFF_RCS 8'h00
`define MCD_OFF_RCNT 8'h04
`define MCD_OFF_RLAT 8'h08
`define MCD_OFF_CFG 8'h0C
`define MCD_OFF_DCS 8'h10
`define MCD_OFF_DA 8'h14
`define MCD_OFF_DB 8'h18
// ----------------------------------------
// field positions
// ----------------------------------------
`define MCD_F_SEL 0
`define MCD_F_DRIVE_TIMEBASE_FIRST 3
`define MCD_F_DRIVE_TIMEBASE_SECOND 4
`define MCD_F_MODE 0
`define MCD_F_TBSEL 4
`define MCD_F_POL 5
`define MCD_F_IL 8
`define MCD_F_ARB 11
`define MCD_F_LVL 14
`define MCD_F_FLAG 15
`define MCD_F_CARB 0
`define MCD_F_PRESCALER_RUN 3
`define MCD_F_VECT 6
// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define MCD_RST_LATCH 16'h0000
`define MCD_RST_CNT 16'h0000
`define MCD_SEL_RISE 3'h6
`define MCD_SEL_FALL 3'h7
`define MCD_MODE_DIS 4'h0
`define MCD_MODE_PULSE_WIDTH_MEASURE 4'h1
`define MCD_MODE_IPM 4'h2
`define MCD_MODE_IC 4'h3
`define MCD_MODE_OCB 4'h4
`define MCD_MODE_COMPARE_FLAG_ON_BOTH 4'h5
`endif

//--- hw/mcd_pkg.sv
// Purpose: shared types of the timer slice
// Assumes: constants live in mcd_regs.svh
// Notes: types only
package mcd_pkg;
   typedef logic [15:0] mcd_word_type;
   typedef logic [3:0] mcd_mode_type;
   typedef logic [2:0] mcd_level_type;
endpackage

//--- hw/mcd_top.sv
// Purpose: reload counter unit and dual action channel behind APB
// Assumes: prescaler taps are one-cycle pulses; pins synchronous inputs
// Notes: zero wait APB slave, one registered read stage
//
// Design decisions made here: the APB register port and the register offsets.
`include "mcd_regs.svh"

// ----------------------------------------
// sticky event flag, read-then-write-zero clear
// ----------------------------------------
module mcd_flag (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // events
   input wire logic set_ev,
   input wire logic rd_seen,
   input wire logic wr_zero,
   // state
   output logic flag
);
   logic armed_q;
   // set wins over a clear in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flag <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         if (set_ev) begin
            flag <= 1'b1;
         end else if (wr_zero && armed_q) begin
            flag <= 1'b0;
         end
         if (wr_zero) begin
            armed_q <= 1'b0;
         end else if (rd_seen && flag) begin
            armed_q <= 1'b1;
         end
      end
   end
endmodule

// What this block does
// - reload latch always readable; write changes latch only, used at next reload
// - counter write loads counter and latch together, counting resumes from it
// - reset clears the reload latch
// - overflow reloads counter from latch and sets overflow flag
// - latch all ones gives an overflow on every count pulse
// - latch zero makes a free running wrapping 16-bit counter
// - 3-bit select picks six prescaler taps or either external edge
// - changing the select never lets external glitches count
// - read-only bit shows synchronised external count input
// - two drive bits pick which time base bus gets the counter
// - overflow requests interrupt if level nonzero, contends above processor mask
// - arbitration id is three config bits plus one submodule bit
// - vector is two config bits over the six-bit submodule number
// - unused bits and addresses read zero, writes ignored
// - channel input modes: disabled, pulse width, period, edge capture
// - channel output modes: compare flag on B, on both, reserved, PWM
// - output flop set by one compare match and cleared by the other
// - software picks one of two time base buses for the channel
// - register roles of A, B1, B2 follow capture, compare or PWM
// - shortest measured or generated pulse is one time base count
// - channel event flag requests interrupt when its level is nonzero
// - counter holds still until prescaler run bit is set
module mcd_top #(
   parameter logic [5:0] RCU_NUM = 6'h0C,
   parameter logic [5:0] DAC_NUM = 6'h09
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // counter clocking
   input wire logic [5:0] PCLK_TAPS,
   input wire logic EXT_COUNT_IN,
   // time base buses
   output mcd_pkg::mcd_word_type TB_OUT,
   output logic TB_FIRST_DRV,
   output logic TB_SECOND_DRV,
   input wire mcd_pkg::mcd_word_type TB_FIRST_IN,
   input wire mcd_pkg::mcd_word_type TB_SECOND_IN,
   // channel pin
   input wire logic CH_PIN_IN,
   output logic CH_PIN_OUT,
   output logic CH_PIN_OE,
   // interrupt arbitration
   input wire mcd_pkg::mcd_level_type IP_MASK,
   output logic IRQ_REQ,
   output mcd_pkg::mcd_level_type IRQ_LEVEL,
   output logic [3:0] ARB_ID,
   output logic [7:0] VECTOR
);
   import mcd_pkg::*;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   logic [7:0] adr;
   logic acc, wr, rd;
   logic s_rcs, s_rcnt, s_rlat, s_cfg, s_dcs, s_da, s_db;
   // transfers act at the access edge; reads are staged in setup
   assign adr = {PADDR[7:2], 2'b00};
   assign acc = PSEL && PENABLE && PREADY;
   assign wr = acc && PWRITE;
   assign rd = acc && !PWRITE;
   assign s_rcs = adr == `MCD_OFF_RCS;
   assign s_rcnt = adr == `MCD_OFF_RCNT;
   assign s_rlat = adr == `MCD_OFF_RLAT;
   assign s_cfg = adr == `MCD_OFF_CFG;
   assign s_dcs = adr == `MCD_OFF_DCS;
   assign s_da = adr == `MCD_OFF_DA;
   assign s_db = adr == `MCD_OFF_DB;

   // ----------------------------------------
   // state
   // ----------------------------------------
   mcd_word_type cnt_q, lat_q;
   logic [2:0] sel_q;
   logic drive_timebase_first_q, drive_timebase_second_q, rarb_q, sel_chg_q;
   mcd_level_type ril_q, dil_q;
   logic [2:0] carb_q;
   logic prescaler_run_q;
   logic [1:0] vect_q;
   mcd_mode_type mode_q;
   logic tbsel_q, pol_q, darb_q;
   mcd_word_type a_q, b1_q, b2_q, tbp_q;
   logic e1_q, e2_q, e3_q, p1_q, p2_q, p3_q, out_q, xfer_q;
   logic rflag, dflag;

   // ----------------------------------------
   // counter clock selection
   // ----------------------------------------
   logic e_rise, e_fall, src, tick, ovf;
   assign e_rise = e2_q && !e3_q;
   assign e_fall = !e2_q && e3_q;
   assign src = (sel_q == `MCD_SEL_RISE) ? e_rise :
                (sel_q == `MCD_SEL_FALL) ? e_fall : PCLK_TAPS[sel_q];
   // one cycle of blanking after a write that changes the select hides stale edges
   assign tick = src && prescaler_run_q && !sel_chg_q;
   assign ovf = tick && (cnt_q == 16'hFFFF) && !(wr && s_rcnt);

   // ----------------------------------------
   // external input synchroniser, e1 feeds e2 only
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         e1_q <= 1'b0;
         e2_q <= 1'b0;
         e3_q <= 1'b0;
      end else begin
         e1_q <= EXT_COUNT_IN;
         e2_q <= e1_q;
         e3_q <= e2_q;
      end
   end

   // ----------------------------------------
   // reload counter and control
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         cnt_q <= `MCD_RST_CNT;
         lat_q <= `MCD_RST_LATCH;
         sel_q <= 3'h0;
         drive_timebase_first_q <= 1'b0;
         drive_timebase_second_q <= 1'b0;
         rarb_q <= 1'b0;
         ril_q <= 3'h0;
         sel_chg_q <= 1'b0;
         carb_q <= 3'h0;
         prescaler_run_q <= 1'b0;
         vect_q <= 2'h0;
      end else begin
         sel_chg_q <= wr && s_rcs && (PWDATA[`MCD_F_SEL +: 3] != sel_q);
         if (wr && s_rcnt) begin
            cnt_q <= PWDATA[15:0];
            lat_q <= PWDATA[15:0];
         end else begin
            if (wr && s_rlat) begin
               lat_q <= PWDATA[15:0];
            end
            if (ovf) begin
               cnt_q <= lat_q;
            end else if (tick) begin
               cnt_q <= cnt_q + 16'h0001;
            end
         end
         if (wr && s_rcs) begin
            sel_q <= PWDATA[`MCD_F_SEL +: 3];
            drive_timebase_first_q <= PWDATA[`MCD_F_DRIVE_TIMEBASE_FIRST];
            drive_timebase_second_q <= PWDATA[`MCD_F_DRIVE_TIMEBASE_SECOND];
            ril_q <= PWDATA[`MCD_F_IL +: 3];
            rarb_q <= PWDATA[`MCD_F_ARB];
         end
         if (wr && s_cfg) begin
            carb_q <= PWDATA[`MCD_F_CARB +: 3];
            prescaler_run_q <= PWDATA[`MCD_F_PRESCALER_RUN];
            vect_q <= PWDATA[`MCD_F_VECT +: 2];
         end
      end
   end

   // ----------------------------------------
   // channel mode decode and timebase
   // ----------------------------------------
   mcd_word_type tb, msk;
   logic m_pwm, m_oc, m_in, step, lead, trail, cap_a, cap_b;
   logic ma, mb, pa, pb, pst, dset;
   assign tb = tbsel_q ? TB_SECOND_IN : TB_FIRST_IN;
   assign m_pwm = mode_q[3];
   assign m_oc = (mode_q == `MCD_MODE_OCB) || (mode_q == `MCD_MODE_COMPARE_FLAG_ON_BOTH);
   assign m_in = !mode_q[3] && !mode_q[2] && (mode_q != `MCD_MODE_DIS);
   // compare only when the bus moves, one event per count
   assign step = tb != tbp_q;
   // resolution 7, 9, 11, then 12 to 16 bits
   assign msk = (mode_q[2:0] == 3'h0) ? 16'h007F :
                (mode_q[2:0] == 3'h1) ? 16'h01FF :
                (mode_q[2:0] == 3'h2) ? 16'h07FF :
                16'hFFFF >> (3'h7 - mode_q[2:0]);
   assign lead = pol_q ? (p2_q && !p3_q) : (!p2_q && p3_q);
   assign trail = pol_q ? (!p2_q && p3_q) : (p2_q && !p3_q);
   assign cap_a = lead && ((mode_q == `MCD_MODE_PULSE_WIDTH_MEASURE) || (mode_q == `MCD_MODE_IC));
   assign cap_b = ((mode_q == `MCD_MODE_PULSE_WIDTH_MEASURE) && trail) ||
                  (((mode_q == `MCD_MODE_IPM) || (mode_q == `MCD_MODE_IC)) && lead);
   assign ma = m_oc && step && (tb == a_q);
   assign mb = m_oc && step && (tb == b2_q);
   assign pa = m_pwm && step && ((tb & msk) == (a_q & msk));
   assign pb = m_pwm && step && ((tb & msk) == (b2_q & msk));
   assign pst = m_pwm && step && ((tb & msk) == 16'h0000);
   assign dset = xfer_q || mb || pst || (ma && (mode_q == `MCD_MODE_COMPARE_FLAG_ON_BOTH));

   // ----------------------------------------
   // channel registers and output flop
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         mode_q <= `MCD_MODE_DIS;
         tbsel_q <= 1'b0;
         pol_q <= 1'b0;
         darb_q <= 1'b0;
         dil_q <= 3'h0;
         a_q <= 16'h0000;
         b1_q <= 16'h0000;
         b2_q <= 16'h0000;
         tbp_q <= 16'h0000;
         p1_q <= 1'b0;
         p2_q <= 1'b0;
         p3_q <= 1'b0;
         out_q <= 1'b0;
         xfer_q <= 1'b0;
      end else begin
         p1_q <= CH_PIN_IN;
         p2_q <= p1_q;
         p3_q <= p2_q;
         tbp_q <= tb;
         xfer_q <= cap_b && m_in;
         if (wr && s_dcs) begin
            mode_q <= PWDATA[`MCD_F_MODE +: 4];
            tbsel_q <= PWDATA[`MCD_F_TBSEL];
            pol_q <= PWDATA[`MCD_F_POL];
            dil_q <= PWDATA[`MCD_F_IL +: 3];
            darb_q <= PWDATA[`MCD_F_ARB];
         end
         // software writes first, hardware events override
         if (wr && s_da) begin
            a_q <= PWDATA[15:0];
         end
         if (wr && s_db && m_pwm) begin
            b1_q <= PWDATA[15:0];
         end
         if (wr && s_db && !m_pwm) begin
            b2_q <= PWDATA[15:0];
         end
         if (cap_a && m_in) begin
            a_q <= tb;
         end
         if (cap_b && m_in) begin
            b1_q <= tb;
         end
         if (xfer_q) begin
            b2_q <= b1_q;
            if (mode_q == `MCD_MODE_IPM) begin
               a_q <= b2_q;
            end
         end
         if (pst) begin
            b2_q <= b1_q;
         end
         if (ma || pa) begin
            out_q <= 1'b1;
         end else if (mb || pb) begin
            out_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // flags
   // ----------------------------------------
   mcd_flag u_rflag (
      .clk(CLK),
      .resetn(RESETN),
      .set_ev(ovf),
      .rd_seen(rd && s_rcs),
      .wr_zero(wr && s_rcs && !PWDATA[`MCD_F_FLAG]),
      .flag(rflag)
   );
   mcd_flag u_dflag (
      .clk(CLK),
      .resetn(RESETN),
      .set_ev(dset),
      .rd_seen(rd && s_dcs),
      .wr_zero(wr && s_dcs && !PWDATA[`MCD_F_FLAG]),
      .flag(dflag)
   );

   // ----------------------------------------
   // read mux, unmapped reads zero
   // ----------------------------------------
   mcd_word_type r_rcs, r_dcs, r_cfg, rmux;
   logic lvl;
   assign lvl = (m_oc || m_pwm) ? out_q : p2_q;
   assign r_rcs = {rflag, e2_q, 2'b00, rarb_q, ril_q, 3'b000, drive_timebase_second_q, drive_timebase_first_q, sel_q};
   assign r_dcs = {dflag, lvl, 2'b00, darb_q, dil_q, 2'b00, pol_q, tbsel_q, mode_q};
   assign r_cfg = {8'h00, vect_q, 2'b00, prescaler_run_q, carb_q};
   assign rmux = s_rcs ? r_rcs :
                 s_rcnt ? cnt_q :
                 s_rlat ? lat_q :
                 s_cfg ? r_cfg :
                 s_dcs ? r_dcs :
                 s_da ? a_q :
                 s_db ? (m_pwm ? b1_q : b2_q) : 16'h0000;

   // ----------------------------------------
   // interrupt arbitration
   // ----------------------------------------
   logic rreq, dreq, pick_d;
   assign rreq = rflag && (ril_q != 3'h0) && (ril_q > IP_MASK);
   assign dreq = dflag && (dil_q != 3'h0) && (dil_q > IP_MASK);
   // higher level wins, the counter takes a tie
   assign pick_d = dreq && (!rreq || (dil_q > ril_q));

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         PRDATA <= 32'h0000_0000;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         TB_OUT <= 16'h0000;
         TB_FIRST_DRV <= 1'b0;
         TB_SECOND_DRV <= 1'b0;
         CH_PIN_OUT <= 1'b0;
         CH_PIN_OE <= 1'b0;
         IRQ_REQ <= 1'b0;
         IRQ_LEVEL <= 3'h0;
         ARB_ID <= 4'h0;
         VECTOR <= 8'h00;
      end else begin
         PREADY <= PSEL && !PENABLE;
         PSLVERR <= 1'b0;
         if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= {16'h0000, rmux};
         end
         TB_OUT <= (wr && s_rcnt) ? PWDATA[15:0] :
                   ovf ? lat_q : tick ? cnt_q + 16'h0001 : cnt_q;
         TB_FIRST_DRV <= drive_timebase_first_q;
         TB_SECOND_DRV <= drive_timebase_second_q;
         CH_PIN_OUT <= out_q;
         CH_PIN_OE <= m_oc || m_pwm;
         IRQ_REQ <= rreq || dreq;
         IRQ_LEVEL <= pick_d ? dil_q : (rreq ? ril_q : 3'h0);
         ARB_ID <= {pick_d ? darb_q : rarb_q, carb_q};
         VECTOR <= {vect_q, pick_d ? DAC_NUM : RCU_NUM};
      end
   end
endmodule

//--- verification/mcd_chk.sv
// Purpose: port-level assertions for the timer slice
// Assumes: aligned APB addresses, zero wait answers
// Notes: bound to mcd_top at the foot of this file
`include "mcd_regs.svh"

module mcd_chk #(
   parameter logic [5:0] RCU_NUM = 6'h0C,
   parameter logic [5:0] DAC_NUM = 6'h09
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // apb
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // watched outputs
   input wire mcd_pkg::mcd_word_type TB_OUT,
   input wire logic TB_FIRST_DRV,
   input wire logic TB_SECOND_DRV,
   input wire logic CH_PIN_OE,
   input wire logic IRQ_REQ,
   input wire mcd_pkg::mcd_level_type IRQ_LEVEL,
   input wire logic [7:0] VECTOR
);
   timeunit 1ns;
   timeprecision 1ps;
   import mcd_pkg::*;
   // -----------------------------
   // committed writes by register
   // -----------------------------
   wire logic acc_wr = PSEL && PENABLE && PREADY && PWRITE;
   wire logic wr_cnt = acc_wr && ((PADDR & 8'hFC) == `MCD_OFF_RCNT);
   wire logic wr_rcs = acc_wr && ((PADDR & 8'hFC) == `MCD_OFF_RCS);
   wire logic wr_dcs = acc_wr && ((PADDR & 8'hFC) == `MCD_OFF_DCS);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);
   // counter only steps by one unless written or reloading from the top
   property p_cnt_step;
      (!$past(wr_cnt) && $past(TB_OUT) != 16'hFFFF) |->
         (TB_OUT == $past(TB_OUT) || TB_OUT == $past(TB_OUT) + 16'h1);
   endproperty
   a_cnt_step: assert property (p_cnt_step) else $error("counter jumped");
   // drive bits move only after a control write, copy may lag one cycle
   property p_drv_hold;
      (!$past(wr_rcs) && !$past(wr_rcs, 2)) |-> $stable({TB_FIRST_DRV, TB_SECOND_DRV});
   endproperty
   a_drv_hold: assert property (p_drv_hold) else $error("drive bits moved");
   property p_oe_hold;
      (!$past(wr_dcs) && !$past(wr_dcs, 2)) |-> $stable(CH_PIN_OE);
   endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("pin enable moved");
   property p_irq_lvl;
      IRQ_REQ |-> IRQ_LEVEL != 3'h0;
   endproperty
   a_irq_lvl: assert property (p_irq_lvl) else $error("request at level zero");
   property p_vec;
      IRQ_REQ |-> (VECTOR[5:0] == RCU_NUM || VECTOR[5:0] == DAC_NUM);
   endproperty
   a_vec: assert property (p_vec) else $error("vector low bits wrong");
   // zero wait answer, one cycle wide
   property p_ready;
      (PSEL && !PENABLE) |=> PREADY ##1 !PREADY;
   endproperty
   a_ready: assert property (p_ready) else $error("no single ready");
   property p_hi_zero;
      PREADY |-> (PRDATA[31:16] == 16'h0 && !PSLVERR);
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("upper bits set");
   property p_unmap;
      (PSEL && PENABLE && !PWRITE && PADDR > 8'h1B) |-> PRDATA == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   c_irq: cover property (IRQ_REQ);
   c_oe: cover property (CH_PIN_OE);
   c_drv: cover property (TB_FIRST_DRV);
endmodule

bind mcd_top mcd_chk #(.RCU_NUM(RCU_NUM), .DAC_NUM(DAC_NUM)) i_mcd_chk (
   .CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TB_OUT(TB_OUT),
   .TB_FIRST_DRV(TB_FIRST_DRV), .TB_SECOND_DRV(TB_SECOND_DRV), .CH_PIN_OE(CH_PIN_OE),
   .IRQ_REQ(IRQ_REQ), .IRQ_LEVEL(IRQ_LEVEL), .VECTOR(VECTOR)
);

//--- verification/mcd_pres_model.sv
// Purpose: prescaler taps and external count source for the counter
// Assumes: taps are one-cycle pulses
// Notes: driven on request from the testbench
module mcd_pres_model (
   // clock
   input wire logic clk,
   // toward the counter
   output logic [5:0] taps,
   output logic ext
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      taps = 6'h00;
      ext = 1'b0;
   end
   // one pulse on a single tap, then quiet
   task automatic tick(input int k);
      taps[k] <= 1'b1;
      @(posedge clk);
      taps <= 6'h00;
      @(posedge clk);
   endtask
   // levels held five cycles: slower than a quarter of the system rate
   task automatic ext_set(input logic v);
      ext <= v;
      repeat (5) @(posedge clk);
   endtask
endmodule

//--- verification/testbench.sv
// Purpose: register-level tests of counter and channel
// Assumes: zero wait APB slave, prescaler model drives taps
// Notes: expectations from the register map in mcd_regs.svh
`include "mcd_regs.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import mcd_pkg::*;
   logic clk = 1'b0, resetn, psel, penable, pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, pin_in, pin_out, pin_oe, drv1, drv2, irq_req, ext;
   logic [5:0] taps;
   mcd_word_type tb1, tb2, tb_out;
   mcd_level_type ip_mask, irq_lvl;
   logic [3:0] arb_id;
   logic [7:0] vector;
   int err_total = 0, cmp_count = 0;
   always #5 clk = ~clk;
   mcd_top i_mcd_top (
      .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .PCLK_TAPS(taps), .EXT_COUNT_IN(ext), .TB_OUT(tb_out), .TB_FIRST_DRV(drv1),
      .TB_SECOND_DRV(drv2), .TB_FIRST_IN(tb1), .TB_SECOND_IN(tb2), .CH_PIN_IN(pin_in),
      .CH_PIN_OUT(pin_out), .CH_PIN_OE(pin_oe), .IP_MASK(ip_mask), .IRQ_REQ(irq_req),
      .IRQ_LEVEL(irq_lvl), .ARB_ID(arb_id), .VECTOR(vector)
   );
   mcd_pres_model i_mcd_pres_model (.clk(clk), .taps(taps), .ext(ext));
   // -----------------------------
   // checking and bus tasks
   // -----------------------------
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one transfer; bounded wait so a silent slave cannot hang the run
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 40) begin
            err_total++;
            tally_and_finish();
         end
         @(posedge clk);
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask
   // -----------------------------
   // main sequence
   // -----------------------------
   initial begin
      // idle levels while reset is held
      resetn <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      pin_in <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h0;
      tb1 <= 16'h0000;
      tb2 <= 16'h0000;
      ip_mask <= 3'h0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rd(`MCD_OFF_RLAT, 32'h0);
      wr(`MCD_OFF_RLAT, 32'h1234);
      rd(`MCD_OFF_RLAT, 32'h1234);
      i_mcd_pres_model.tick(0);
      rd(`MCD_OFF_RCNT, 32'h0);
      $display("test latch done");
      wr(`MCD_OFF_CFG, 32'hCD);
      wr(`MCD_OFF_RCNT, 32'hFFFE);
      rd(`MCD_OFF_RLAT, 32'hFFFE);
      i_mcd_pres_model.tick(0);
      rd(`MCD_OFF_RCNT, 32'hFFFF);
      wr(`MCD_OFF_RLAT, 32'h0);
      i_mcd_pres_model.tick(0);
      rd(`MCD_OFF_RCNT, 32'h0);
      rd(`MCD_OFF_RCS, 32'h8000);
      wr(`MCD_OFF_RCNT, 32'hFFFF);
      wr(`MCD_OFF_RLAT, 32'h0040);
      i_mcd_pres_model.tick(0);
      rd(`MCD_OFF_RCNT, 32'h0040);
      wr(`MCD_OFF_RCNT, 32'hFFFF);
      // every pulse overflows with an all-ones latch; clear each time
      for (int i = 0; i < 2; i++) begin
         i_mcd_pres_model.tick(0);
         rd(`MCD_OFF_RCNT, 32'hFFFF);
         rd(`MCD_OFF_RCS, 32'h8000);
         wr(`MCD_OFF_RCS, 32'h0);
         rd(`MCD_OFF_RCS, 32'h0);
      end
      $display("test overflow done");
      wr(`MCD_OFF_RCS, 32'h0B00);
      i_mcd_pres_model.tick(0);
      repeat (2) @(posedge clk);
      chk({irq_req, irq_lvl, arb_id, vector}, 32'hBDCC);
      ip_mask <= 3'h3;
      repeat (3) @(posedge clk);
      chk(irq_req, 32'h0);
      ip_mask <= 3'h0;
      rd(`MCD_OFF_RCS, 32'h8B00);
      wr(`MCD_OFF_RCS, 32'h0);
      for (int i = 0; i < 2; i++) begin
         wr(`MCD_OFF_RCS, 32'h8 << i);
         repeat (2) @(posedge clk);
         chk({drv2, drv1}, 32'h1 << i);
      end
      chk(tb_out, 32'hFFFF);
      wr(`MCD_OFF_RCS, 32'hFFFF20E0);
      rd(`MCD_OFF_RCS, 32'h0);
      wr(8'h1C, 32'h5A5A);
      rd(8'h1C, 32'h0);
      $display("test interrupt done");
      wr(`MCD_OFF_RCS, 32'h6);
      wr(`MCD_OFF_RCNT, 32'h0);
      i_mcd_pres_model.ext_set(1'b1);
      rd(`MCD_OFF_RCNT, 32'h1);
      rd(`MCD_OFF_RCS, 32'h4006);
      wr(`MCD_OFF_RCS, 32'h7);
      rd(`MCD_OFF_RCNT, 32'h1);
      i_mcd_pres_model.ext_set(1'b0);
      rd(`MCD_OFF_RCNT, 32'h2);
      // taps 1 to 5 count when selected; the tap below, unselected, does not
      for (int k = 1; k < 6; k++) begin
         wr(`MCD_OFF_RCS, k);
         i_mcd_pres_model.tick(k);
         i_mcd_pres_model.tick(k - 1);
         rd(`MCD_OFF_RCNT, 2 + k);
      end
      $display("test clock select done");
      pin_in <= 1'b1;
      repeat (3) @(posedge clk);
      rd(`MCD_OFF_DCS, 32'h4000);
      chk(pin_oe, 32'h0);
      pin_in <= 1'b0;
      wr(`MCD_OFF_DCS, 32'h23);
      tb1 <= 16'h0077;
      repeat (2) @(posedge clk);
      pin_in <= 1'b1;
      repeat (5) @(posedge clk);
      rd(`MCD_OFF_DA, 32'h77);
      rd(`MCD_OFF_DB, 32'h77);
      rd(`MCD_OFF_DCS, 32'hC023);
      wr(`MCD_OFF_DCS, 32'h33);
      tb2 <= 16'h0099;
      pin_in <= 1'b0;
      repeat (5) @(posedge clk);
      pin_in <= 1'b1;
      repeat (5) @(posedge clk);
      rd(`MCD_OFF_DA, 32'h99);
      rd(`MCD_OFF_DCS, 32'hC033);
      // pulse width: lead edge into A, trail edge into B
      pin_in <= 1'b0;
      repeat (5) @(posedge clk);
      wr(`MCD_OFF_DCS, 32'h21);
      tb1 <= 16'h0011;
      pin_in <= 1'b1;
      repeat (5) @(posedge clk);
      tb1 <= 16'h0022;
      pin_in <= 1'b0;
      repeat (5) @(posedge clk);
      rd(`MCD_OFF_DA, 32'h11);
      rd(`MCD_OFF_DB, 32'h22);
      // period: older lead edge moves to A, newer one to B
      wr(`MCD_OFF_DCS, 32'h22);
      tb1 <= 16'h0033;
      pin_in <= 1'b1;
      repeat (5) @(posedge clk);
      pin_in <= 1'b0;
      repeat (5) @(posedge clk);
      tb1 <= 16'h0044;
      pin_in <= 1'b1;
      repeat (5) @(posedge clk);
      rd(`MCD_OFF_DA, 32'h33);
      rd(`MCD_OFF_DB, 32'h44);
      rd(`MCD_OFF_DCS, 32'hC022);
      $display("test capture done");
      wr(`MCD_OFF_DCS, 32'h4);
      wr(`MCD_OFF_DA, 32'h10);
      wr(`MCD_OFF_DB, 32'h20);
      tb1 <= 16'h0010;
      repeat (3) @(posedge clk);
      chk({pin_oe, pin_out}, 32'h3);
      rd(`MCD_OFF_DCS, 32'h4004);
      tb1 <= 16'h0020;
      repeat (3) @(posedge clk);
      chk({pin_oe, pin_out}, 32'h2);
      rd(`MCD_OFF_DCS, 32'h8004);
      wr(`MCD_OFF_DCS, 32'h205);
      tb1 <= 16'h0010;
      repeat (3) @(posedge clk);
      chk({irq_req, irq_lvl, arb_id, vector}, 32'hA5C9);
      rd(`MCD_OFF_DCS, 32'hC205);
      wr(`MCD_OFF_DCS, 32'h6);
      repeat (2) @(posedge clk);
      chk(pin_oe, 32'h0);
      wr(`MCD_OFF_DCS, 32'h8);
      repeat (2) @(posedge clk);
      chk(pin_oe, 32'h1);
      // 7-bit pwm: masked zero loads B2 from B1, later B writes wait
      wr(`MCD_OFF_DA, 32'h05);
      wr(`MCD_OFF_DB, 32'h30);
      tb1 <= 16'h0180;
      repeat (2) @(posedge clk);
      wr(`MCD_OFF_DB, 32'h50);
      tb1 <= 16'h01B0;
      repeat (3) @(posedge clk);
      chk({pin_oe, pin_out}, 32'h2);
      tb1 <= 16'h0185;
      repeat (3) @(posedge clk);
      chk({pin_oe, pin_out}, 32'h3);
      rd(`MCD_OFF_DB, 32'h50);
      rd(`MCD_OFF_DCS, 32'hC008);
      $display("test compare done");
      tally_and_finish();
   end
endmodule
